// *** rtl/timer16_cfg.svh ***
// register map, field positions, reset values and limits of the timer
// assumes an 8-bit cpu data bus with a 4-bit register address
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// ====================================================================
// register addresses
`define T16_ADDR_SYNC     4'h0
`define T16_ADDR_CTRL_A   4'h1
`define T16_ADDR_CTRL_B   4'h2
`define T16_ADDR_CNT_LO   4'h3
`define T16_ADDR_CNT_HI   4'h4
`define T16_ADDR_CMPA_LO  4'h5
`define T16_ADDR_CMPA_HI  4'h6
`define T16_ADDR_CMPB_LO  4'h7
`define T16_ADDR_CMPB_HI  4'h8
`define T16_ADDR_CAP_LO   4'h9
`define T16_ADDR_CAP_HI   4'ha
`define T16_ADDR_FLAG     4'hb
`define T16_ADDR_MASK     4'hc

// ====================================================================
// field positions
`define T16_SYNC_HOLD_BIT 7
`define T16_PRESCALER_ZERO_RESET_BIT      1
`define T16_PRESCALER_ONE_RESET_BIT      0
`define T16_CS_LSB        0
`define T16_TOPSEL_LSB    3
`define T16_CAP_SRC_BIT   0
`define T16_CAP_EDGE_BIT  6
`define T16_NOISE_EN_BIT  7
`define T16_OVF_BIT       0
`define T16_CMPA_BIT      1
`define T16_CMPB_BIT      2
`define T16_CAP_BIT       5

// ====================================================================
// reset values and counter limits
`define T16_RESET_BYTE    8'h00
`define T16_RESET_WORD    16'h0000
`define T16_BOTTOM        16'h0000
`define T16_MAX           16'hffff
`define T16_TOP_8BIT      16'h00ff
`define T16_TOP_9BIT      16'h01ff
`define T16_TOP_10BIT     16'h03ff

`endif

// *** rtl/timer16_pkg.sv ***
// types shared by the timer files
// assumes the constants of timer16_cfg.svh
package timer16_pkg;

	// ================================================================
	// clock source select
	typedef enum logic [2:0] {
		CS_STOP    = 3'b000,
		CS_DIV1    = 3'b001,
		CS_DIV8    = 3'b010,
		CS_DIV64   = 3'b011,
		CS_DIV256  = 3'b100,
		CS_DIV1024 = 3'b101,
		CS_EXT_FALL= 3'b110,
		CS_EXT_RISE= 3'b111
	} clock_select_type;

	// ================================================================
	// top limit select
	typedef enum logic [2:0] {
		TOP_MAX     = 3'b000,
		TOP_8BIT    = 3'b001,
		TOP_9BIT    = 3'b010,
		TOP_10BIT   = 3'b011,
		TOP_CMP_A   = 3'b100,
		TOP_CAPTURE = 3'b101
	} top_select_type;

endpackage : timer16_pkg

// *** rtl/timer16_prescaler.sv ***
// shared prescaler and clock select, one count pulse per timer clock
// assumes the external clock pin is already synchronous to i_clock
`timescale 1ns/1ns
`include "timer16_cfg.svh"

module timer16_prescaler
	import timer16_pkg::*;
#(
	parameter int DIV_WIDTH = 10
) (
	input  wire logic             i_clock,
	input  wire logic             i_rstn,
	input  wire logic             i_prescaler_reset,
	input  wire clock_select_type i_select,
	input  wire logic             i_ext_clock_pin,
	output logic                  o_tick
);

	logic [DIV_WIDTH-1:0] divider;
	logic                 ext_prev;
	logic                 next_tick;

	wire ext_rise = i_ext_clock_pin & ~ext_prev;
	wire ext_fall = ~i_ext_clock_pin & ext_prev;

	// ================================================================
	// divider, restarted by i_prescaler_reset (wired to the timer one reset bit) and by i_rstn
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			divider  <= '0;
			ext_prev <= 1'b0;
			o_tick   <= 1'b0;
		end else begin
			divider  <= i_prescaler_reset ? '0 : divider + 1'b1;
			ext_prev <= i_ext_clock_pin;
			o_tick   <= next_tick;
		end
	end

	always_comb begin
		unique case (i_select)
			CS_STOP:     next_tick = 1'b0;
			CS_DIV1:     next_tick = 1'b1;
			CS_DIV8:     next_tick = &divider[2:0] & ~i_prescaler_reset;
			CS_DIV64:    next_tick = &divider[5:0] & ~i_prescaler_reset;
			CS_DIV256:   next_tick = &divider[7:0] & ~i_prescaler_reset;
			CS_DIV1024:  next_tick = &divider[9:0] & ~i_prescaler_reset;
			CS_EXT_FALL: next_tick = ext_fall;
			CS_EXT_RISE: next_tick = ext_rise;
		endcase
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	prescale_restart_a: assert property (
		i_prescaler_reset |=> divider == '0)
		else $error("prescaler did not restart");

endmodule : timer16_prescaler

// *** rtl/timer16_prescaler_sync_access.sv ***
// 16-bit timer front end: sync control, limits, compare, capture,
// shared high-byte holding register on an 8-bit cpu bus
// assumes single-cycle read and write strobes synchronous to i_clock
`timescale 1ns/1ns
`include "timer16_cfg.svh"

module timer16_prescaler_sync_access
	import timer16_pkg::*;
#(
	parameter int NOISE_SAMPLES = 4,
	parameter int DIV_WIDTH     = 10
) (
	input  wire logic       i_clock,
	input  wire logic       i_rstn,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_write,
	input  wire logic       i_read,
	input  wire logic       i_capture_input_pin,
	input  wire logic       i_comparator_out,
	input  wire logic       i_ext_clock_pin,
	output logic      [7:0] o_rdata,
	output logic            o_timer0_prescaler_reset,
	output logic            o_irq_overflow,
	output logic            o_irq_compare_a,
	output logic            o_irq_compare_b,
	output logic            o_irq_capture,
	output logic            o_at_bottom,
	output logic            o_at_max,
	output logic            o_at_top
);

	// ================================================================
	// state
	logic                     sync_hold_bit;
	logic                     prescaler_zero_reset;
	logic                     prescaler_one_reset;
	logic               [7:0] control_a;
	logic               [7:0] control_b;
	logic              [15:0] count_value;
	logic              [15:0] compare_reg_a;
	logic              [15:0] compare_reg_b;
	logic              [15:0] compare_act_a;
	logic              [15:0] compare_act_b;
	logic              [15:0] capture_reg;
	logic               [7:0] high_temp;
	logic                     overflow_flag;
	logic                     compare_a_flag;
	logic                     compare_b_flag;
	logic                     capture_flag;
	logic               [7:0] interrupt_mask_reg;
	logic [NOISE_SAMPLES-1:0] capture_hist;
	logic                     capture_level;
	logic                     capture_prev;
	logic                     tick;

	logic                     next_sync;
	logic                     next_prescaler_zero_reset;
	logic                     next_prescaler_one_reset;
	logic              [15:0] next_count;
	logic               [7:0] next_temp;
	logic              [15:0] top_value;
	logic               [7:0] read_mux;

	// ================================================================
	// address decode
	wire wr_sync   = i_write && i_addr == `T16_ADDR_SYNC;
	wire wr_ctrl_a = i_write && i_addr == `T16_ADDR_CTRL_A;
	wire wr_ctrl_b = i_write && i_addr == `T16_ADDR_CTRL_B;
	wire wr_cnt_lo = i_write && i_addr == `T16_ADDR_CNT_LO;
	wire wr_cma_lo = i_write && i_addr == `T16_ADDR_CMPA_LO;
	wire wr_cmb_lo = i_write && i_addr == `T16_ADDR_CMPB_LO;
	wire wr_cap_lo = i_write && i_addr == `T16_ADDR_CAP_LO;
	wire wr_flag   = i_write && i_addr == `T16_ADDR_FLAG;
	wire wr_mask   = i_write && i_addr == `T16_ADDR_MASK;
	wire wr_high   = i_write && (i_addr == `T16_ADDR_CNT_HI
		|| i_addr == `T16_ADDR_CMPA_HI || i_addr == `T16_ADDR_CMPB_HI
		|| i_addr == `T16_ADDR_CAP_HI);
	wire rd_cnt_lo = i_read && i_addr == `T16_ADDR_CNT_LO;
	wire rd_cap_lo = i_read && i_addr == `T16_ADDR_CAP_LO;

	wire clock_select_type clock_sel =
		clock_select_type'(control_a[`T16_CS_LSB +: 3]);
	wire top_select_type   top_sel   =
		top_select_type'(control_a[`T16_TOPSEL_LSB +: 3]);
	wire capture_from_comp = control_b[`T16_CAP_SRC_BIT];
	wire capture_rising    = control_b[`T16_CAP_EDGE_BIT];
	wire noise_enable      = control_b[`T16_NOISE_EN_BIT];

	// ================================================================
	// sync control
	always_comb begin
		next_sync = sync_hold_bit;
		next_prescaler_zero_reset = prescaler_zero_reset;
		next_prescaler_one_reset = prescaler_one_reset;
		if (wr_sync) begin
			next_sync = i_wdata[`T16_SYNC_HOLD_BIT];
			if (sync_hold_bit && !i_wdata[`T16_SYNC_HOLD_BIT]) begin
				next_prescaler_zero_reset = 1'b0;
				next_prescaler_one_reset = 1'b0;
			end else begin
				next_prescaler_zero_reset = i_wdata[`T16_PRESCALER_ZERO_RESET_BIT];
				next_prescaler_one_reset = i_wdata[`T16_PRESCALER_ONE_RESET_BIT];
			end
		end else if (!sync_hold_bit) begin
			next_prescaler_zero_reset = 1'b0;
			next_prescaler_one_reset = 1'b0;
		end
	end

	timer16_prescaler #(
		.DIV_WIDTH (DIV_WIDTH)
	) prescaler (
		.i_clock           (i_clock),
		.i_rstn            (i_rstn),
		.i_prescaler_reset (prescaler_one_reset),
		.i_select          (clock_sel),
		.i_ext_clock_pin   (i_ext_clock_pin),
		.o_tick            (tick)
	);

	// ================================================================
	// counter and limits
	always_comb begin
		unique case (top_sel)
			TOP_MAX:     top_value = `T16_MAX;
			TOP_8BIT:    top_value = `T16_TOP_8BIT;
			TOP_9BIT:    top_value = `T16_TOP_9BIT;
			TOP_10BIT:   top_value = `T16_TOP_10BIT;
			TOP_CMP_A:   top_value = compare_act_a;
			TOP_CAPTURE: top_value = capture_reg;
			default:     top_value = `T16_MAX;
		endcase
	end

	wire at_top       = count_value == top_value;
	wire wrap         = tick && at_top;
	wire buffered     = top_sel != TOP_MAX;
	wire load_compare = !buffered || wrap;
	wire match_a      = tick && !wr_cnt_lo && count_value == compare_act_a;
	wire match_b      = tick && !wr_cnt_lo && count_value == compare_act_b;
	wire ovf_set      = wrap && !wr_cnt_lo;

	always_comb begin
		if (wr_cnt_lo)
			next_count = {high_temp, i_wdata};
		else if (wrap)
			next_count = `T16_BOTTOM;
		else if (tick)
			next_count = count_value + 16'h0001;
		else
			next_count = count_value;
	end

	// ================================================================
	// capture source select and edge detect
	wire capture_src  = capture_from_comp ? i_comparator_out
		: i_capture_input_pin;
	wire capture_edge = capture_rising ? capture_level & ~capture_prev
		: ~capture_level & capture_prev;
	wire capture_take = capture_edge && !wr_cap_lo;

	// ================================================================
	// cpu holding register and read path
	always_comb begin
		if (wr_high)
			next_temp = i_wdata;
		else if (rd_cnt_lo)
			next_temp = count_value[15:8];
		else if (rd_cap_lo)
			next_temp = capture_reg[15:8];
		else
			next_temp = high_temp;
	end

	always_comb begin
		unique case (i_addr)
			`T16_ADDR_SYNC:    read_mux = {sync_hold_bit, 5'h00,
				prescaler_zero_reset, prescaler_one_reset};
			`T16_ADDR_CTRL_A:  read_mux = control_a;
			`T16_ADDR_CTRL_B:  read_mux = control_b;
			`T16_ADDR_CNT_LO:  read_mux = count_value[7:0];
			`T16_ADDR_CNT_HI:  read_mux = high_temp;
			`T16_ADDR_CMPA_LO: read_mux = compare_reg_a[7:0];
			`T16_ADDR_CMPA_HI: read_mux = compare_reg_a[15:8];
			`T16_ADDR_CMPB_LO: read_mux = compare_reg_b[7:0];
			`T16_ADDR_CMPB_HI: read_mux = compare_reg_b[15:8];
			`T16_ADDR_CAP_LO:  read_mux = capture_reg[7:0];
			`T16_ADDR_CAP_HI:  read_mux = high_temp;
			`T16_ADDR_FLAG:    read_mux = {2'h0, capture_flag, 2'h0,
				compare_b_flag, compare_a_flag, overflow_flag};
			`T16_ADDR_MASK:    read_mux = interrupt_mask_reg;
			default:           read_mux = 8'h00;
		endcase
	end

	wire clr_ovf  = wr_flag && i_wdata[`T16_OVF_BIT];
	wire clr_cmpa = wr_flag && i_wdata[`T16_CMPA_BIT];
	wire clr_cmpb = wr_flag && i_wdata[`T16_CMPB_BIT];
	wire clr_cap  = wr_flag && i_wdata[`T16_CAP_BIT];

	// ================================================================
	// control and cpu registers
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			sync_hold_bit        <= 1'b0;
			prescaler_zero_reset <= 1'b0;
			prescaler_one_reset  <= 1'b0;
			control_a            <= `T16_RESET_BYTE;
			control_b            <= `T16_RESET_BYTE;
			interrupt_mask_reg   <= `T16_RESET_BYTE;
			high_temp            <= `T16_RESET_BYTE;
			o_rdata              <= `T16_RESET_BYTE;
			o_timer0_prescaler_reset <= 1'b0;
		end else begin
			sync_hold_bit        <= next_sync;
			prescaler_zero_reset <= next_prescaler_zero_reset;
			prescaler_one_reset  <= next_prescaler_one_reset;
			if (wr_ctrl_a)
				control_a <= i_wdata;
			if (wr_ctrl_b)
				control_b <= i_wdata;
			if (wr_mask)
				interrupt_mask_reg <= i_wdata;
			high_temp            <= next_temp;
			if (i_read)
				o_rdata <= read_mux;
			o_timer0_prescaler_reset <= next_prescaler_zero_reset;
		end
	end

	// ================================================================
	// counter, compare, capture registers
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			count_value   <= `T16_RESET_WORD;
			compare_reg_a <= `T16_RESET_WORD;
			compare_reg_b <= `T16_RESET_WORD;
			compare_act_a <= `T16_RESET_WORD;
			compare_act_b <= `T16_RESET_WORD;
			capture_reg   <= `T16_RESET_WORD;
			o_at_bottom   <= 1'b1;
			o_at_max      <= 1'b0;
			o_at_top      <= 1'b0;
		end else begin
			count_value <= next_count;
			if (wr_cma_lo)
				compare_reg_a <= {high_temp, i_wdata};
			if (wr_cmb_lo)
				compare_reg_b <= {high_temp, i_wdata};
			if (load_compare) begin
				compare_act_a <= compare_reg_a;
				compare_act_b <= compare_reg_b;
			end
			if (wr_cap_lo)
				capture_reg <= {high_temp, i_wdata};
			else if (capture_edge)
				capture_reg <= count_value;
			o_at_bottom <= next_count == `T16_BOTTOM;
			o_at_max    <= next_count == `T16_MAX;
			o_at_top    <= next_count == top_value;
		end
	end

	// ================================================================
	// flags, capture filter, interrupt requests
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			overflow_flag   <= 1'b0;
			compare_a_flag  <= 1'b0;
			compare_b_flag  <= 1'b0;
			capture_flag    <= 1'b0;
			capture_hist    <= '0;
			capture_level   <= 1'b0;
			capture_prev    <= 1'b0;
			o_irq_overflow  <= 1'b0;
			o_irq_compare_a <= 1'b0;
			o_irq_compare_b <= 1'b0;
			o_irq_capture   <= 1'b0;
		end else begin
			// set wins over a same-cycle clear
			overflow_flag  <= ovf_set | (overflow_flag & ~clr_ovf);
			compare_a_flag <= match_a | (compare_a_flag & ~clr_cmpa);
			compare_b_flag <= match_b | (compare_b_flag & ~clr_cmpb);
			capture_flag   <= capture_take | (capture_flag & ~clr_cap);
			capture_hist   <= {capture_hist[NOISE_SAMPLES-2:0], capture_src};
			if (!noise_enable)
				capture_level <= capture_src;
			else if (&capture_hist)
				capture_level <= 1'b1;
			else if (~|capture_hist)
				capture_level <= 1'b0;
			capture_prev    <= capture_level;
			o_irq_overflow  <= overflow_flag
				& interrupt_mask_reg[`T16_OVF_BIT];
			o_irq_compare_a <= compare_a_flag
				& interrupt_mask_reg[`T16_CMPA_BIT];
			o_irq_compare_b <= compare_b_flag
				& interrupt_mask_reg[`T16_CMPB_BIT];
			o_irq_capture   <= capture_flag
				& interrupt_mask_reg[`T16_CAP_BIT];
		end
	end

	// ================================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	sequence spike_s;
		!capture_src ##1 capture_src ##1 !capture_src;
	endsequence

	sequence stopped_s;
		(clock_sel == CS_STOP)[*2] ##0 !wr_cnt_lo;
	endsequence

	sync_hold_a: assert property (
		sync_hold_bit && prescaler_one_reset && !wr_sync
		|=> prescaler_one_reset)
		else $error("reset bit dropped in sync mode");

	sync_release_a: assert property (
		wr_sync && sync_hold_bit && !i_wdata[`T16_SYNC_HOLD_BIT]
		|=> !prescaler_zero_reset && !prescaler_one_reset
		&& (!tick || $past(clock_sel) inside {CS_DIV1, CS_EXT_FALL,
		CS_EXT_RISE}))
		else $error("sync release left a reset bit set");

	prescaler_one_reset_clear_a: assert property (
		prescaler_one_reset && !sync_hold_bit && !wr_sync
		|=> !prescaler_one_reset)
		else $error("timer one reset bit not cleared");

	no_source_a: assert property (
		stopped_s |=> count_value == $past(count_value))
		else $error("counter moved with no source");

	compare_flag_a: assert property (
		match_a |=> compare_a_flag ##1 o_irq_compare_a
		|| !interrupt_mask_reg[`T16_CMPA_BIT])
		else $error("compare a match lost");

	capture_copy_a: assert property (
		capture_take |=> capture_reg == $past(count_value) && capture_flag)
		else $error("capture did not copy count");

	noise_reject_a: assert property (
		noise_enable && capture_hist == '0 && !capture_level
		##0 spike_s |=> !capture_level [*3])
		else $error("filter passed a short spike");

	top_buffer_a: assert property (
		top_sel == TOP_CMP_A && !wrap
		|=> compare_act_a == $past(compare_act_a))
		else $error("compare a top changed mid period");

	bottom_flag_a: assert property (
		o_at_bottom == (count_value == `T16_BOTTOM))
		else $error("bottom indication wrong");

	max_flag_a: assert property (
		o_at_max == (count_value == `T16_MAX))
		else $error("max indication wrong");

	top_wrap_a: assert property (
		wrap && !wr_cnt_lo |=> count_value == `T16_BOTTOM && overflow_flag)
		else $error("counter did not wrap at top");

	low_read_a: assert property (
		rd_cnt_lo |=> high_temp == $past(count_value[15:8])
		&& o_rdata == $past(count_value[7:0]))
		else $error("low read did not latch high byte");

	low_write_a: assert property (
		wr_cnt_lo |=> count_value == {$past(high_temp), $past(i_wdata)})
		else $error("low write did not load word");

	compare_read_a: assert property (
		i_read && i_addr == `T16_ADDR_CMPA_HI
		|=> o_rdata == $past(compare_reg_a[15:8]) && $stable(high_temp))
		else $error("compare high read used holder");

	irq_gate_a: assert property (
		!interrupt_mask_reg[`T16_OVF_BIT] |=> !o_irq_overflow)
		else $error("masked overflow request raised");

	prescaler_zero_reset_hold_a: assert property (
		sync_hold_bit && prescaler_zero_reset && !wr_sync
		|=> prescaler_zero_reset && o_timer0_prescaler_reset)
		else $error("timer zero reset bit dropped in sync mode");

endmodule : timer16_prescaler_sync_access

// *** tb/test_timer16_prescaler_sync_access.sv ***
// self-checking bench of the timer front end
// assumes the cpu model drives the bus and the bench drives the pins
`timescale 1ns/1ns
`include "timer16_cfg.svh"

module test_timer16_prescaler_sync_access;
	logic        clk;
	logic        rstn;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic        wr_en;
	logic        rd_en;
	logic        cap_pin;
	logic        comp_out;
	logic        ext_pin;
	logic [7:0]  rdata;
	logic        t0_rst;
	logic [3:0]  irq;
	logic        at_bot;
	logic        at_max;
	logic        at_top;
	logic [7:0]  b;
	logic [15:0] w;
	int          n_mismatch;
	int          check_count;

	timer16_prescaler_sync_access i_dut (
		.i_clock(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
		.i_write(wr_en), .i_read(rd_en), .i_capture_input_pin(cap_pin),
		.i_comparator_out(comp_out), .i_ext_clock_pin(ext_pin),
		.o_rdata(rdata), .o_timer0_prescaler_reset(t0_rst),
		.o_irq_overflow(irq[0]), .o_irq_compare_a(irq[1]),
		.o_irq_compare_b(irq[2]), .o_irq_capture(irq[3]),
		.o_at_bottom(at_bot), .o_at_max(at_max), .o_at_top(at_top)
	);

	timer16_cpu_model i_cpu (
		.i_clock(clk), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_write(wr_en), .o_read(rd_en)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ================================================================
	// comparison and closing
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	task automatic pin_step(input logic p, input logic c, input int n);
		@(posedge clk);
		#1;
		cap_pin  = p;
		comp_out = c;
		repeat (n) @(posedge clk);
	endtask : pin_step

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		report_and_stop;
	end

	// ================================================================
	// test sequence
	initial begin
		n_mismatch = 0;
		check_count = 0;
		rstn = 1'b0;
		cap_pin = 1'b0;
		comp_out = 1'b0;
		ext_pin = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rstn = 1'b1;
		i_cpu.rd(`T16_ADDR_SYNC, b);
		check({8'h00, b}, 16'h0000);
		check({15'h0, at_bot}, 16'h0001);
		$display("test reset done");

		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h01ff);
		repeat (20) @(posedge clk);
		i_cpu.rd16(`T16_ADDR_CNT_LO, w);
		check(w, 16'h01ff);
		i_cpu.wr16(`T16_ADDR_CMPA_LO, 16'h1234);
		i_cpu.rd(`T16_ADDR_CNT_LO, b);
		i_cpu.rd(`T16_ADDR_CMPA_HI, b);
		check({8'h00, b}, 16'h0012);
		i_cpu.rd(`T16_ADDR_CNT_HI, b);
		check({8'h00, b}, 16'h0001);
		i_cpu.wr(`T16_ADDR_CNT_HI, 8'h77);
		i_cpu.rd16(`T16_ADDR_CNT_LO, w);
		check(w, 16'h01ff);
		$display("test word access done");

		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'hffff);
		check({15'h0, at_max}, 16'h0001);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h08);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h00ff);
		check({14'h0, at_top, at_max}, 16'h0002);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h0000);
		check({15'h0, at_bot}, 16'h0001);
		$display("test limits done");

		i_cpu.wr(`T16_ADDR_SYNC, 8'h83);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h02);
		repeat (40) @(posedge clk);
		i_cpu.rd(`T16_ADDR_SYNC, b);
		check({8'h00, b}, 16'h0083);
		check({15'h0, t0_rst}, 16'h0001);
		i_cpu.rd16(`T16_ADDR_CNT_LO, w);
		check(w, 16'h0000);
		i_cpu.wr(`T16_ADDR_SYNC, 8'h00);
		i_cpu.rd(`T16_ADDR_SYNC, b);
		check({8'h00, b}, 16'h0000);
		check({15'h0, t0_rst}, 16'h0000);
		repeat (100) @(posedge clk);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h00);
		i_cpu.rd16(`T16_ADDR_CNT_LO, w);
		check({15'h0, w != 16'h0000}, 16'h0001);
		for (int k = 1; k < 3; k++) begin
			i_cpu.wr(`T16_ADDR_SYNC, k[7:0]);
			i_cpu.rd(`T16_ADDR_SYNC, b);
			check({8'h00, b}, 16'h0000);
		end
		$display("test sync done");

		i_cpu.wr(`T16_ADDR_MASK, 8'ha5);
		i_cpu.rd(`T16_ADDR_MASK, b);
		check({8'h00, b}, 16'h00a5);
		i_cpu.wr(`T16_ADDR_MASK, 8'h23);
		i_cpu.wr16(`T16_ADDR_CMPA_LO, 16'h0005);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h0000);
		i_cpu.wr(`T16_ADDR_FLAG, 8'hff);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h01);
		repeat (20) @(posedge clk);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h00);
		i_cpu.rd(`T16_ADDR_FLAG, b);
		check({8'h00, b & 8'h03}, 16'h0002);
		check({12'h0, irq}, 16'h0002);
		i_cpu.wr(`T16_ADDR_FLAG, 8'hff);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h00f0);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h09);
		repeat (30) @(posedge clk);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h00);
		i_cpu.rd(`T16_ADDR_FLAG, b);
		check({8'h00, b & 8'h01}, 16'h0001);
		check({15'h0, irq[0]}, 16'h0001);
		i_cpu.wr(`T16_ADDR_FLAG, 8'hff);
		i_cpu.rd(`T16_ADDR_FLAG, b);
		check({8'h00, b}, 16'h0000);
		$display("test flags done");

		i_cpu.wr(`T16_ADDR_CTRL_B, 8'h40);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h0abc);
		pin_step(1'b1, 1'b0, 4);
		i_cpu.rd16(`T16_ADDR_CAP_LO, w);
		check(w, 16'h0abc);
		check({15'h0, irq[3]}, 16'h0001);
		i_cpu.wr(`T16_ADDR_FLAG, 8'hff);
		pin_step(1'b0, 1'b0, 8);
		i_cpu.wr(`T16_ADDR_CTRL_B, 8'hc0);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h0123);
		pin_step(1'b1, 1'b0, 0);
		pin_step(1'b0, 1'b0, 10);
		i_cpu.rd16(`T16_ADDR_CAP_LO, w);
		check(w, 16'h0abc);
		pin_step(1'b1, 1'b0, 12);
		i_cpu.rd16(`T16_ADDR_CAP_LO, w);
		check(w, 16'h0123);
		i_cpu.wr(`T16_ADDR_CTRL_B, 8'h41);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h0456);
		pin_step(1'b0, 1'b1, 4);
		i_cpu.rd16(`T16_ADDR_CAP_LO, w);
		check(w, 16'h0456);
		$display("test capture done");

		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h10);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h01ff);
		check({15'h0, at_top}, 16'h0001);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h18);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h03ff);
		check({15'h0, at_top}, 16'h0001);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h28);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h0456);
		check({15'h0, at_top}, 16'h0001);
		i_cpu.wr16(`T16_ADDR_CNT_LO, 16'h0000);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h07);
		repeat (3) begin
			@(posedge clk);
			#1 ext_pin = 1'b1;
			repeat (2) @(posedge clk);
			#1 ext_pin = 1'b0;
			repeat (2) @(posedge clk);
		end
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h00);
		i_cpu.rd16(`T16_ADDR_CNT_LO, w);
		check(w, 16'h0003);
		i_cpu.wr(`T16_ADDR_FLAG, 8'hff);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h21);
		repeat (20) @(posedge clk);
		i_cpu.wr16(`T16_ADDR_CMPA_LO, 16'h0300);
		repeat (10) @(posedge clk);
		i_cpu.wr(`T16_ADDR_CTRL_A, 8'h00);
		i_cpu.rd16(`T16_ADDR_CNT_LO, w);
		check({15'h0, w > 16'h0005}, 16'h0001);
		i_cpu.rd(`T16_ADDR_FLAG, b);
		check({8'h00, b & 8'h01}, 16'h0001);
		$display("test top select done");
		report_and_stop;
	end
endmodule : test_timer16_prescaler_sync_access

// *** tb/timer16_cpu_model.sv ***
// cpu side of the timer: byte and word transfers on the 8-bit bus
// assumes single-cycle strobes sampled on the rising edge of i_clock
`timescale 1ns/1ns

module timer16_cpu_model (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_rdata,
	output logic      [3:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_write,
	output logic            o_read
);
	initial begin
		o_addr  = 4'h0;
		o_wdata = 8'h00;
		o_write = 1'b0;
		o_read  = 1'b0;
	end

	// ================================================================
	// byte transfers, one idle cycle after each
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clock);
		#1;
		o_addr  = a;
		o_wdata = d;
		o_write = 1'b1;
		@(posedge i_clock);
		#1;
		o_write = 1'b0;
		// released data line must not look valid
		o_wdata = ~d;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_clock);
		#1;
		o_addr = a;
		o_read = 1'b1;
		@(posedge i_clock);
		#1;
		o_read = 1'b0;
		d      = i_rdata;
	endtask : rd

	// ================================================================
	// word transfers through the shared high byte
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a + 4'h1, v[15:8]);
		wr(a, v[7:0]);
	endtask : wr16

	task automatic rd16(input logic [3:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 4'h1, v[15:8]);
	endtask : rd16
endmodule : timer16_cpu_model
